// file: verilog/odt_pkg.sv
package odt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  TIMING_OFS     = 8'h04;
  localparam logic [7:0]  STATUS_OFS     = 8'h08;
  localparam int          CTRL_WL_LSB    = 0;
  localparam int          CTRL_NOM_BIT   = 4;
  localparam int          CTRL_WR_LSB    = 5;
  localparam int          CTRL_DLL_BIT   = 7;
  localparam int          CTRL_PDDLL_BIT = 8;
  localparam int          TIM_CPDED_LSB  = 0;
  localparam int          TIM_XPDLL_LSB  = 8;
  localparam int          TIM_RFC_LSB    = 16;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0085;
  localparam logic [31:0] TIMING_RESET   = 32'h00D0_0A01;

  // ----------------------------------------------------------------
  // latency and timing constants
  // ----------------------------------------------------------------
  localparam int ODTL_SUB    = 2;
  localparam int CWN4_ADD    = 4;
  localparam int CWN8_ADD    = 6;
  localparam int CLK_PS      = 20000;
  localparam int AONPD_MIN_PS = 2000;
  localparam int AONPD_MAX_PS = 8500;
  localparam int AONPD_MIN_CYC = (AONPD_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int AONPD_MAX_CYC = (AONPD_MAX_PS / CLK_PS) < 1 ? 1 : (AONPD_MAX_PS / CLK_PS);
  localparam int ASYNC_DLY   = (AONPD_MIN_CYC > AONPD_MAX_CYC) ? AONPD_MAX_CYC : AONPD_MIN_CYC;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTT_OFF = 2'b00,
    RTT_NOM = 2'b01,
    RTT_WR  = 2'b10
  } rtt_e;

  typedef enum logic [3:0] {
    PM_SYNC  = 4'b0001,
    PM_ENTRY = 4'b0010,
    PM_ASYNC = 4'b0100,
    PM_EXIT  = 4'b1000
  } pm_e;

  typedef struct packed {
    logic ck;
    logic odt;
    logic cke;
    logic wr_cmd;
    logic wr_bl8;
    logic ref_cmd;
  } link_s;

endpackage

// file: verilog/odt_ctrl.sv
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
module odt_ctrl #(
  parameter int HIST = 32
) (
  // clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rstn,
  // apb slave
  input  wire logic           i_psel,
  input  wire logic           i_penable,
  input  wire logic           i_pwrite,
  input  wire logic [7:0]     i_paddr,
  input  wire logic [31:0]    i_pwdata,
  output logic      [31:0]    o_prdata,
  output logic                o_pready,
  output logic                o_pslverr,
  // memory pins
  input  wire odt_pkg::link_s i_link,
  // termination
  output odt_pkg::rtt_e       o_rtt,
  output logic                o_async
);
  import odt_pkg::*;

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic        rst_a;
  logic        rstn;
  link_s       link_m;
  link_s       link_q;
  logic        ck_d;
  logic        ck_rise;
  logic        ck_fall;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_a <= 1'b0;
      rstn  <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rstn  <= rst_a;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      link_m <= '0;
      link_q <= '0;
      ck_d   <= 1'b0;
    end else begin
      link_m <= i_link;
      link_q <= link_m;
      ck_d   <= link_q.ck;
    end
  end

  assign ck_rise = link_q.ck & ~ck_d;
  assign ck_fall = ~link_q.ck & ck_d;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] timing;
  logic [31:0] status;
  logic        addr_ok;
  logic [3:0]  wl;
  logic        nom_en;
  logic [1:0]  wr_sel;
  logic        dll_on;
  logic        pd_dll_on;
  logic [7:0]  t_cpded;
  logic [7:0]  t_xpdll;
  logic [7:0]  t_rfc;
  pm_e         pm;
  rtt_e        rtt;
  logic        ref_busy;

  assign wl        = ctrl[CTRL_WL_LSB +: 4];
  assign nom_en    = ctrl[CTRL_NOM_BIT];
  assign wr_sel    = ctrl[CTRL_WR_LSB +: 2];
  assign dll_on    = ctrl[CTRL_DLL_BIT];
  assign pd_dll_on = ctrl[CTRL_PDDLL_BIT];
  assign t_cpded   = timing[TIM_CPDED_LSB +: 8];
  assign t_xpdll   = timing[TIM_XPDLL_LSB +: 8];
  assign t_rfc     = timing[TIM_RFC_LSB +: 8];
  assign status    = {24'h00_0000, ref_busy, (pm == PM_ASYNC), pm, rtt};
  assign addr_ok   = (i_paddr == CTRL_OFS) || (i_paddr == TIMING_OFS) || (i_paddr == STATUS_OFS);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl   <= CTRL_RESET;
      timing <= TIMING_RESET;
    end else if (i_psel && i_penable && i_pwrite) begin
      if (i_paddr == CTRL_OFS) begin
        ctrl <= {23'h00_0000, i_pwdata[8:0]};
      end
      if (i_paddr == TIMING_OFS) begin
        timing <= {8'h00, i_pwdata[23:0]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        CTRL_OFS:   o_prdata <= ctrl;
        TIMING_OFS: o_prdata <= timing;
        STATUS_OFS: o_prdata <= status;
        default:    o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // odt and write history on ck rising edges
  // ----------------------------------------------------------------
  logic [HIST-1:0] odt_hist;
  logic [HIST-1:0] wr_hist;
  logic [HIST-1:0] bl8_hist;
  logic [HIST-1:0] next_wr_hist;
  logic [HIST-1:0] next_bl8_hist;
  logic [4:0]      odtl;
  logic            cmd_ok;
  logic            sync_on_now;
  logic            wr_win_now;

  // write window: strength switch at odtl, back at odtl+4 or odtl+6
  function automatic logic in_wr_window(input logic [HIST-1:0] w, input logic [HIST-1:0] b,
                                        input logic [4:0] lat);
    logic hit;
    int   lim;
    hit = 1'b0;
    for (int i = 0; i < HIST; i++) begin
      lim = int'(lat) + (b[i] ? CWN8_ADD : CWN4_ADD);
      if (w[i] && (i >= int'(lat)) && (i < lim)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign odtl          = {1'b0, wl} - 5'(ODTL_SUB);
  assign cmd_ok        = link_q.cke && (pm == PM_SYNC);
  assign next_wr_hist  = {wr_hist[HIST-2:0], link_q.wr_cmd & cmd_ok};
  assign next_bl8_hist = {bl8_hist[HIST-2:0], link_q.wr_bl8};
  assign sync_on_now   = (odtl == 5'h00) ? link_q.odt : odt_hist[odtl - 5'h01];
  assign wr_win_now    = in_wr_window(next_wr_hist, next_bl8_hist, odtl);

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      odt_hist <= '0;
      wr_hist  <= '0;
      bl8_hist <= '0;
    end else if (ck_rise) begin
      odt_hist <= {odt_hist[HIST-2:0], link_q.odt};
      wr_hist  <= next_wr_hist;
      bl8_hist <= next_bl8_hist;
    end
  end

  // ----------------------------------------------------------------
  // synchronous termination: on at rise, off and strength at fall
  // ----------------------------------------------------------------
  logic sync_on;
  logic pend_on;
  logic wr_act;
  logic pend_wr;

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      sync_on <= 1'b0;
      pend_on <= 1'b0;
    end else if (ck_rise) begin
      pend_on <= sync_on_now;
      if (sync_on_now) begin
        sync_on <= 1'b1;
      end
    end else if (ck_fall) begin
      sync_on <= pend_on;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      wr_act  <= 1'b0;
      pend_wr <= 1'b0;
    end else if (ck_rise) begin
      pend_wr <= wr_win_now && (wr_sel != 2'b00);
    end else if (ck_fall) begin
      wr_act <= pend_wr;
    end
  end

  // ----------------------------------------------------------------
  // asynchronous path: pin level after ASYNC_DLY clock cycles, without odtl
  // ----------------------------------------------------------------
  logic [ASYNC_DLY-1:0] async_pipe;

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      async_pipe <= '0;
    end else begin
      async_pipe <= ASYNC_DLY'({async_pipe, link_q.odt});
    end
  end

  // ----------------------------------------------------------------
  // refresh tracking
  // ----------------------------------------------------------------
  logic [7:0] rfc_cnt;

  assign ref_busy = (rfc_cnt != 8'h00);

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      rfc_cnt <= 8'h00;
    end else if (ck_rise) begin
      if (link_q.ref_cmd && cmd_ok) begin
        rfc_cnt <= t_rfc;
      end else if (ref_busy) begin
        rfc_cnt <= rfc_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // power-down mode state machine
  // ----------------------------------------------------------------
  pm_e        next_pm;
  logic [7:0] pm_cnt;
  logic [7:0] next_pm_cnt;
  logic       cke_prev;
  logic       frozen_pd;

  assign frozen_pd = dll_on && !pd_dll_on;

  always_comb begin
    next_pm     = pm;
    next_pm_cnt = pm_cnt;
    if (ck_rise) begin
      case (pm)
        PM_SYNC: begin
          if (!link_q.cke && cke_prev && frozen_pd) begin
            next_pm     = PM_ENTRY;
            next_pm_cnt = (ref_busy && ((rfc_cnt - 8'h01) > t_cpded)) ? (rfc_cnt - 8'h01) : t_cpded;
          end
        end
        PM_ENTRY: begin
          if (link_q.cke) begin
            next_pm     = PM_EXIT;
            next_pm_cnt = t_xpdll;
          end else if (pm_cnt <= 8'h01) begin
            next_pm     = PM_ASYNC;
            next_pm_cnt = 8'h00;
          end else begin
            next_pm_cnt = pm_cnt - 8'h01;
          end
        end
        PM_ASYNC: begin
          if (link_q.cke) begin
            next_pm     = PM_EXIT;
            next_pm_cnt = t_xpdll;
          end
        end
        PM_EXIT: begin
          if (!link_q.cke) begin
            next_pm     = PM_ENTRY;
            next_pm_cnt = t_cpded;
          end else if (pm_cnt <= 8'h01) begin
            next_pm     = PM_SYNC;
            next_pm_cnt = 8'h00;
          end else begin
            next_pm_cnt = pm_cnt - 8'h01;
          end
        end
        default: begin
          next_pm     = PM_SYNC;
          next_pm_cnt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      pm       <= PM_SYNC;
      pm_cnt   <= 8'h00;
      cke_prev <= 1'b0;
    end else begin
      pm     <= next_pm;
      pm_cnt <= next_pm_cnt;
      if (ck_rise) begin
        cke_prev <= link_q.cke;
      end
    end
  end

  // ----------------------------------------------------------------
  // termination select
  // ----------------------------------------------------------------
  rtt_e next_rtt;

  always_comb begin
    next_rtt = RTT_OFF;
    if (pm == PM_ASYNC) begin
      if (async_pipe[ASYNC_DLY-1] && nom_en) begin
        next_rtt = RTT_NOM;
      end
    end else if (sync_on) begin
      if (wr_act) begin
        next_rtt = RTT_WR;
      end else if (nom_en) begin
        next_rtt = RTT_NOM;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      rtt <= RTT_OFF;
    end else begin
      rtt <= next_rtt;
    end
  end

  assign o_rtt   = rtt;
  assign o_async = (pm == PM_ASYNC);

endmodule

// file: verification/odt_ctrl_assertions.sv
`timescale 1ns/10ps
module odt_ctrl_assertions
  import odt_pkg::*;
(
  // clock and reset
  input wire logic           i_clk,
  input wire logic           i_rstn,
  // apb
  input wire logic           i_psel,
  input wire logic           i_penable,
  input wire logic           i_pwrite,
  input wire logic [7:0]     i_paddr,
  input wire logic [31:0]    i_pwdata,
  input wire logic [31:0]    o_prdata,
  input wire logic           o_pready,
  input wire logic           o_pslverr,
  // pins and termination
  input wire odt_pkg::link_s i_link,
  input wire odt_pkg::rtt_e  o_rtt,
  input wire logic           o_async
);
  logic [7:0] odt_age;
  logic [7:0] wr_age;

  // ----------------------------------------
  // cycles since odt high and since a write
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) odt_age <= 8'hFF;
    else if (i_link.odt) odt_age <= 8'h00;
    else if (odt_age != 8'hFF) odt_age <= odt_age + 8'h01;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) wr_age <= 8'hFF;
    else if (i_link.wr_cmd) wr_age <= 8'h00;
    else if (wr_age != 8'hFF) wr_age <= wr_age + 8'h01;
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_ready_high: assert property (o_pready)
    else $error("pready low");
  a_err_unmapped: assert property (i_psel && i_penable && i_paddr > 8'h08 |-> o_pslverr)
    else $error("no error on unmapped access");
  a_err_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access");
  a_rtt_coded: assert property (o_rtt != 2'b11)
    else $error("bad termination code");
  a_on_needs_odt: assert property (o_rtt != RTT_OFF |-> odt_age < 8'hC8)
    else $error("termination on without odt");
  a_wr_needs_cmd: assert property (o_rtt == RTT_WR |-> wr_age < 8'hC8)
    else $error("write strength without write");
  a_async_nominal: assert property (o_async |-> o_rtt != RTT_WR)
    else $error("write strength in power-down");
  a_async_off: assert property (o_async && $past(o_async, 4) && !$past(i_link.odt, 3)
    && !$past(i_link.odt, 4) |-> o_rtt == RTT_OFF)
    else $error("async turn-off late");
  a_async_entry: assert property ($rose(o_async) |-> !$past(i_link.cke, 3))
    else $error("async mode without cke low");
  a_exit_cke: assert property ($fell(o_async) |-> $past(i_link.cke, 3))
    else $error("async left without cke high");

  c_async: cover property ($rose(o_async));
  c_write: cover property (o_rtt == RTT_WR);
  c_error: cover property (o_pslverr);
endmodule

bind odt_ctrl odt_ctrl_assertions odt_ctrl_assertions_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_link(i_link), .o_rtt(o_rtt), .o_async(o_async));

// file: verification/ddr_ctrl_model.sv
`timescale 1ns/10ps
module ddr_ctrl_model
  import odt_pkg::*;
(
  // pin requests: odt, cke, write, bl8, refresh
  input  wire logic [4:0] i_req,
  // memory pins
  output odt_pkg::link_s  o_link
);
  logic       ck;
  logic [4:0] pins = 5'b01000;

  // ----------------------------------------
  // free-running ck, pins move on its fall
  // ----------------------------------------
  initial begin
    ck = 1'b0;
    #7;
    forever #80 ck = ~ck;
  end
  always @(negedge ck) pins <= i_req;
  assign o_link = {ck, pins};
endmodule

// file: verification/odt_ctrl_bench.sv
`timescale 1ns/10ps
module odt_ctrl_bench;
  import odt_pkg::*;
  logic        i_clk;
  logic        i_rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  req;
  link_s       link;
  rtt_e        rtt;
  logic        async;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          checked;

  odt_ctrl odt_ctrl_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_link(link), .o_rtt(rtt), .o_async(async));
  ddr_ctrl_model ddr_ctrl_model_i (.i_req(req), .o_link(link));

  // ----------------------------------------
  // clock, tasks and scenarios
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task pin(input logic [4:0] v);
    @(posedge i_clk);
    req <= v;
    @(negedge link.ck);
    @(posedge link.ck);
    @(posedge i_clk);
    req <= v & 5'b11010;
  endtask
  task at(input int n, input int k, input rtt_e e);
    repeat (n) @(posedge link.ck);
    repeat (k) @(posedge i_clk);
    #1;
    check({30'h0, rtt}, {30'h0, e});
  endtask
  task t_regs;
    rdc(CTRL_OFS, CTRL_RESET);
    rdc(TIMING_OFS, TIMING_RESET);
    rdc(STATUS_OFS, 32'h0000_0004);
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    rdc(STATUS_OFS, 32'h0000_0004);
    apb(1'b0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0000_0095);
    rdc(CTRL_OFS, 32'h0000_0095);
  endtask
  task t_sync;
    pin(5'b11000);
    at(2, 5, RTT_OFF);
    at(1, 5, RTT_NOM);
    pin(5'b01000);
    at(3, 5, RTT_NOM);
    at(1, 5, RTT_OFF);
  endtask
  task t_dyn;
    logic [1:0] sel;
    logic       b;
    int         n;
    rtt_e       w;
    for (int i = 0; i < 3; i++) begin
      sel = i[1:0];
      b = (i != 1);
      n = b ? CWN8_ADD : CWN4_ADD;
      w = (sel != 2'b00) ? RTT_WR : RTT_NOM;
      apb(1'b1, CTRL_OFS, 32'h0000_0095 | {25'h0, sel, 5'h0});
      pin({3'b111, b, 1'b0});
      at(4, 5, w);
      at(n - 1, 5, w);
      at(1, 5, RTT_NOM);
      pin(5'b01000);
      at(4, 5, RTT_OFF);
    end
  endtask
  task t_pd;
    apb(1'b1, TIMING_OFS, 32'h0014_0A02);
    apb(1'b1, CTRL_OFS, 32'h0000_00B5);
    pin(5'b00000);
    at(5, 1, RTT_OFF);
    check({31'h0, async}, 32'h1);
    rdc(STATUS_OFS, 32'h0000_0050);
    pin(5'b10000);
    at(0, 1, RTT_NOM);
    pin(5'b10110);
    at(4, 5, RTT_NOM);
    pin(5'b00000);
    at(0, 1, RTT_OFF);
    pin(5'b01000);
    at(3, 5, RTT_OFF);
    check({31'h0, async}, 32'h0);
    rdc(STATUS_OFS, 32'h0000_0020);
    repeat (12) @(posedge link.ck);
    rdc(STATUS_OFS, 32'h0000_0004);
  endtask
  task t_refresh;
    pin(5'b01001);
    pin(5'b00000);
    at(10, 1, RTT_OFF);
    check({31'h0, async}, 32'h0);
    rdc(STATUS_OFS, 32'h0000_0088);
    at(8, 5, RTT_OFF);
    check({31'h0, async}, 32'h0);
    at(1, 5, RTT_OFF);
    check({31'h0, async}, 32'h1);
    pin(5'b01000);
    repeat (12) @(posedge link.ck);
  endtask
  task t_keep;
    apb(1'b1, CTRL_OFS, 32'h0000_01B5);
    pin(5'b00000);
    at(6, 1, RTT_OFF);
    check({31'h0, async}, 32'h0);
    pin(5'b01000);
    apb(1'b1, CTRL_OFS, 32'h0000_0015);
    pin(5'b11110);
    at(4, 5, RTT_NOM);
    pin(5'b01000);
    at(4, 5, RTT_OFF);
  endtask

  initial begin
    i_rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = 5'b01000;
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs;
    t_sync;
    t_dyn;
    t_pd;
    t_refresh;
    t_keep;
    test_done;
  end
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
endmodule
